// *** frp_guard.v ***
// Access checker for flash readout protection and write protection.
// What this block does
// - Two write-protected page ranges per bank; erase and program inside them refused.
// - Four protection levels 0, 0.5, 1, 2; level 0 restricts no context.
// - Level 0.5 only with security extension; secure debug blocked, non-secure allowed.
// - Level 1 denies flash access to debug, RAM boot or bootloader.
// - Level 1 with security extension: non-secure debug allowed, SRAM boot prevented.
// - Optional password must be presented before leaving level 1 for level 0 or 0.5.
// - Level 2 disables debug, RAM boot and bootloader selection.
// - Level 2 without key is permanent; debug interfaces stay off.
// - Level 2 with key regresses to 1 after debug password match.
// - System memory is read-only in every level and context.
// - Option bytes change only via control path and option-start.
// - Level 2 blocks option writes except the bank-swap bit.
// - Each one-time area word is written once only between resets.
// - Going from level 1 to 0 erases all main flash.
// - Going from level 1 to 0 clears backup registers.
// - Going from level 1 to 0 erases every SRAM.
// - Going from level 1 to 0 erases decryption unit keys.
// - ECC corrects single, flags double errors and records failing address.
// - Each bank holds 128 pages of 8 Kbytes.
// - Reads from one bank served while the other bank erases or programs.
// - Prefetch enable flag, off after reset, enabled by configuration.
// Assumes all inputs synchronous to sys_clk; option byte values come from outside.
`timescale 1ns/100ps
`include "frp_map.vh"

module frp_guard #(
	parameter KEY_BITS  = 64,
	parameter PAGE_BITS = `FRP_PAGE_BITS,
	parameter WIPE_CYC  = `FRP_WIPE_CYC
)(
	input  wire                 sys_clk,
	input  wire                 rst,
	// Option byte image
	input  wire [1:0]           opt_level,
	input  wire                 security_extension_enable,
	input  wire                 opt_key_set,
	input  wire [KEY_BITS-1:0]  opt_key,
	input  wire                 opt_pwd_needed,
	input  wire [PAGE_BITS-1:0] wp_a_start,
	input  wire [PAGE_BITS-1:0] wp_a_end,
	input  wire                 wp_a_en,
	input  wire [PAGE_BITS-1:0] wp_b_start,
	input  wire [PAGE_BITS-1:0] wp_b_end,
	input  wire                 wp_b_en,
	input  wire [PAGE_BITS-1:0] wp_c_start,
	input  wire [PAGE_BITS-1:0] wp_c_end,
	input  wire                 wp_c_en,
	input  wire [PAGE_BITS-1:0] wp_d_start,
	input  wire [PAGE_BITS-1:0] wp_d_end,
	input  wire                 wp_d_en,
	// Execution context
	input  wire                 debug_connected,
	input  wire                 debug_secure,
	input  wire                 boot_ram,
	input  wire                 boot_loader,
	// Access request
	input  wire                 req_valid,
	input  wire [2:0]           req_area,
	input  wire [1:0]           req_op,
	input  wire                 req_secure,
	input  wire                 req_bank,
	input  wire [PAGE_BITS-1:0] req_page,
	input  wire                 req_direct,
	input  wire [4:0]           req_word,
	input  wire [31:0]          req_wdata,
	input  wire                 opt_swap_only,
	// Option update through the control path
	input  wire                 option_update_start,
	input  wire [1:0]           opt_new_level,
	// Debug password presentation
	input  wire                 pwd_valid,
	input  wire [KEY_BITS-1:0]  pwd_value,
	// Flash bank activity
	input  wire                 bank_busy_0,
	input  wire                 bank_busy_1,
	// ECC syndrome report from the array, and prefetch enable
	input  wire                 ecc_valid,
	input  wire                 ecc_single,
	input  wire                 ecc_double,
	input  wire [31:0]          ecc_addr,
	input  wire                 prefetch_enable,
	// Answers
	output reg                  grant_reg,
	output reg                  deny_reg,
	output reg                  wait_reg,
	output reg  [31:0]          otp_rdata,
	output reg  [1:0]           readout_protect_level,
	output reg                  debug_enable_reg,
	output reg                  ram_boot_enable_reg,
	output reg                  loader_enable_reg,
	output reg                  wipe_busy_reg,
	output reg                  wipe_flash_reg,
	output reg                  wipe_backup_reg,
	output reg                  wipe_sram_reg,
	output reg                  wipe_keys_reg,
	output reg                  ecc_corrected_reg,
	output reg                  ecc_failed_reg,
	output reg  [31:0]          ecc_fail_addr_reg,
	output reg                  prefetch_on_reg,
	output reg                  pwd_ok_reg
);
	// Wipe sequencer states, one-hot
	localparam ST_IDLE  = 5'h01;
	localparam ST_FLASH = 5'h02;
	localparam ST_BKP   = 5'h04;
	localparam ST_SRAM  = 5'h08;
	localparam ST_KEYS  = 5'h10;

	reg  [4:0]  state_reg;
	reg  [4:0]  state_next;
	reg  [7:0]  cnt_reg;
	reg         grant_next;
	reg         deny_next;
	reg         wait_next;
	wire [31:0] otp_q;
	wire        otp_used;
	wire        otp_wr;
	wire        ctx_user;

	// Page inside an enabled range
	function in_range;
		input                 en;
		input [PAGE_BITS-1:0] lo;
		input [PAGE_BITS-1:0] hi;
		input [PAGE_BITS-1:0] pg;
		begin
			in_range = en && (pg >= lo) && (pg <= hi);
		end
	endfunction

	// Page falls in a write-protected area of its bank
	function wp_hit;
		input                 bank;
		input [PAGE_BITS-1:0] pg;
		begin
			if (bank)
				wp_hit = in_range(wp_c_en, wp_c_start, wp_c_end, pg) ||
					in_range(wp_d_en, wp_d_start, wp_d_end, pg);
			else
				wp_hit = in_range(wp_a_en, wp_a_start, wp_a_end, pg) ||
					in_range(wp_b_en, wp_b_start, wp_b_end, pg);
		end
	endfunction

	// Anything other than user boot from flash is the restricted context
	assign ctx_user = !debug_connected && !boot_ram && !boot_loader;
	assign otp_wr   = grant_next && req_area == `FRP_AREA_OTP && req_op == `FRP_OP_WRITE;

	frp_otp_mem #(
		.WIDTH (32),
		.ABITS (`FRP_OTP_BITS)
	) u_otp (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.wr_en       (otp_wr),
		.addr        (req_word),
		.wr_data     (req_wdata),
		.rd_data_reg (otp_q),
		.used        (otp_used)
	);

	// Access decision table; a wipe in progress blocks everything
	always @*
	begin
		grant_next = 1'b0;
		deny_next  = 1'b0;
		wait_next  = 1'b0;
		if (req_valid)
		begin
			if (state_reg != ST_IDLE)
				deny_next = 1'b1;
			else
			begin
				case (req_area)
				`FRP_AREA_SYSMEM:
					grant_next = (req_op == `FRP_OP_READ);
				`FRP_AREA_OPTION:
					if (req_op == `FRP_OP_READ)
						grant_next = 1'b1;
					else if (req_op == `FRP_OP_ERASE || req_direct)
						grant_next = 1'b0;
					else if (readout_protect_level == `FRP_LVL_2)
						grant_next = opt_swap_only;
					else
						grant_next = 1'b1;
				`FRP_AREA_OTP:
					if (req_op == `FRP_OP_READ)
						grant_next = 1'b1;
					else
						grant_next = (req_op == `FRP_OP_WRITE) && !otp_used;
				`FRP_AREA_DECRYPT:
					// Decryption regions stay unreadable from debug at level 1
					grant_next = ctx_user || req_op != `FRP_OP_READ ||
						readout_protect_level == `FRP_LVL_0;
				default:
				begin
					// Flash, backup registers, SRAM share the level rule
					if (ctx_user || readout_protect_level == `FRP_LVL_0)
						grant_next = 1'b1;
					else if (readout_protect_level == `FRP_LVL_HALF)
						grant_next = !req_secure && !debug_secure;
					else if (readout_protect_level == `FRP_LVL_1 &&
						security_extension_enable && debug_connected &&
						!debug_secure && !req_secure && !boot_ram && !boot_loader)
						grant_next = 1'b1;
					else
						grant_next = 1'b0;
					if (req_area == `FRP_AREA_FLASH && req_op != `FRP_OP_READ &&
						wp_hit(req_bank, req_page))
						grant_next = 1'b0;
					if (req_area != `FRP_AREA_FLASH && req_op == `FRP_OP_ERASE)
						grant_next = 1'b0;
					// Same-bank read stalls during program; other bank runs freely
					if (grant_next && req_area == `FRP_AREA_FLASH &&
						req_op == `FRP_OP_READ &&
						(req_bank ? bank_busy_1 : bank_busy_0))
					begin
						grant_next = 1'b0;
						wait_next  = 1'b1;
					end
				end
				endcase
				deny_next = !grant_next && !wait_next;
			end
		end
	end

	// Answer registers and one-time area read data
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			grant_reg <= 1'b0;
			deny_reg  <= 1'b0;
			wait_reg  <= 1'b0;
			otp_rdata <= 32'h00000000;
		end
		else
		begin
			grant_reg <= grant_next;
			deny_reg  <= deny_next;
			wait_reg  <= wait_next;
			otp_rdata <= otp_q;
		end
	end

	// Level 2 context lockout; level 1 with the security extension also blocks RAM boot
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			debug_enable_reg    <= 1'b0;
			ram_boot_enable_reg <= 1'b0;
			loader_enable_reg   <= 1'b0;
		end
		else
		begin
			debug_enable_reg    <= readout_protect_level != `FRP_LVL_2;
			ram_boot_enable_reg <= readout_protect_level == `FRP_LVL_0 ||
				readout_protect_level == `FRP_LVL_HALF ||
				(readout_protect_level == `FRP_LVL_1 && !security_extension_enable);
			loader_enable_reg   <= readout_protect_level != `FRP_LVL_2;
		end
	end

	// Password match latch; a mismatch withdraws earlier approval
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pwd_ok_reg <= 1'b0;
		else if (pwd_valid)
			pwd_ok_reg <= opt_key_set && (pwd_value == opt_key);
		else if (option_update_start && state_next == ST_IDLE)
			pwd_ok_reg <= 1'b0;
	end

	// Level register: loaded from option bytes at reset release via first edge
	reg loaded_reg;
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			readout_protect_level <= `FRP_LVL_2;
			loaded_reg            <= 1'b0;
		end
		else if (!loaded_reg)
		begin
			// Half level collapses to 1 without the security extension
			readout_protect_level <= (opt_level == `FRP_LVL_HALF &&
				!security_extension_enable) ? `FRP_LVL_1 : opt_level;
			loaded_reg            <= 1'b1;
		end
		else if (option_update_start && state_reg == ST_IDLE)
		begin
			if (readout_protect_level == `FRP_LVL_2)
			begin
				// Only keyed regression to 1, only after password match
				if (opt_new_level == `FRP_LVL_1 && opt_key_set && pwd_ok_reg)
					readout_protect_level <= `FRP_LVL_1;
			end
			else if (opt_new_level == `FRP_LVL_HALF && !security_extension_enable)
				readout_protect_level <= readout_protect_level;
			else if (readout_protect_level == `FRP_LVL_1 &&
				opt_new_level != `FRP_LVL_1 && opt_new_level != `FRP_LVL_2 &&
				opt_pwd_needed && !pwd_ok_reg)
				readout_protect_level <= readout_protect_level;
			else
				readout_protect_level <= opt_new_level;
		end
	end

	// Wipe sequencer: starts when leaving level 1 for level 0
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE:
			if (loaded_reg && option_update_start &&
				readout_protect_level == `FRP_LVL_1 &&
				opt_new_level == `FRP_LVL_0 &&
				(!opt_pwd_needed || pwd_ok_reg))
				state_next = ST_FLASH;
		ST_FLASH:
			if (cnt_reg == 8'h00)
				state_next = ST_BKP;
		ST_BKP:
			if (cnt_reg == 8'h00)
				state_next = ST_SRAM;
		ST_SRAM:
			if (cnt_reg == 8'h00)
				state_next = ST_KEYS;
		ST_KEYS:
			if (cnt_reg == 8'h00)
				state_next = ST_IDLE;
		default:
			state_next = ST_IDLE;
		endcase
	end

	// Each wipe step held for a fixed erase time
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			if (state_next != state_reg)
				cnt_reg <= WIPE_CYC[7:0] - 8'h01;
			else if (cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
		end
	end

	// Wipe strobes held for their whole step
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wipe_busy_reg   <= 1'b0;
			wipe_flash_reg  <= 1'b0;
			wipe_backup_reg <= 1'b0;
			wipe_sram_reg   <= 1'b0;
			wipe_keys_reg   <= 1'b0;
		end
		else
		begin
			wipe_busy_reg   <= state_next != ST_IDLE;
			wipe_flash_reg  <= state_next == ST_FLASH;
			wipe_backup_reg <= state_next == ST_BKP;
			wipe_sram_reg   <= state_next == ST_SRAM;
			wipe_keys_reg   <= state_next == ST_KEYS;
		end
	end

	// ECC report capture; each single or double error records its failing address
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ecc_corrected_reg <= 1'b0;
			ecc_failed_reg    <= 1'b0;
			ecc_fail_addr_reg <= 32'h00000000;
			prefetch_on_reg   <= `FRP_PREFETCH_RST;
		end
		else
		begin
			ecc_corrected_reg <= ecc_valid && ecc_single && !ecc_double;
			ecc_failed_reg    <= ecc_valid && ecc_double;
			if (ecc_valid && (ecc_single || ecc_double))
				ecc_fail_addr_reg <= ecc_addr;
			prefetch_on_reg   <= prefetch_enable;
		end
	end
endmodule // frp_guard

// *** frp_guard_monitor.sv ***
// Port-level checks on the readout protection access guard.
// Assumes it is bound onto frp_guard and sees only its ports.
`timescale 1ns/100ps
`include "frp_map.vh"
module frp_guard_monitor #(
	parameter PAGE_BITS = 7,
	parameter WIPE_CYC  = 8
)(
	input logic                 sys_clk,
	input logic                 rst,
	input logic                 debug_connected,
	input logic                 boot_ram,
	input logic                 boot_loader,
	input logic                 security_extension_enable,
	input logic                 req_valid,
	input logic [2:0]           req_area,
	input logic [1:0]           req_op,
	input logic                 req_bank,
	input logic [PAGE_BITS-1:0] req_page,
	input logic                 req_direct,
	input logic [PAGE_BITS-1:0] wp_a_start,
	input logic [PAGE_BITS-1:0] wp_a_end,
	input logic                 wp_a_en,
	input logic                 ecc_valid,
	input logic                 ecc_single,
	input logic                 ecc_double,
	input logic [31:0]          ecc_addr,
	input logic                 grant_reg,
	input logic                 deny_reg,
	input logic                 wait_reg,
	input logic [1:0]           readout_protect_level,
	input logic                 debug_enable_reg,
	input logic                 ram_boot_enable_reg,
	input logic                 loader_enable_reg,
	input logic                 wipe_busy_reg,
	input logic                 wipe_flash_reg,
	input logic                 wipe_backup_reg,
	input logic                 wipe_sram_reg,
	input logic                 wipe_keys_reg,
	input logic                 ecc_corrected_reg,
	input logic                 ecc_failed_reg,
	input logic [31:0]          ecc_fail_addr_reg
);
	localparam int WS = WIPE_CYC;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Any context other than user boot from flash
	wire restricted = debug_connected | boot_ram | boot_loader;
	// Wipe steps follow one another at fixed spacing
	sequence s_wipe;
		wipe_flash_reg ##WS wipe_backup_reg ##WS wipe_sram_reg ##WS wipe_keys_reg;
	endsequence
	a_one_answer: assert property (
		req_valid |=> $onehot({grant_reg, deny_reg, wait_reg}))
		else $error("request answered other than once");
	a_sysmem_ro: assert property (
		req_valid && req_area == `FRP_AREA_SYSMEM && req_op != `FRP_OP_READ |=> deny_reg)
		else $error("system memory change not refused");
	a_direct_opt: assert property (
		req_valid && req_area == `FRP_AREA_OPTION && req_op == `FRP_OP_WRITE && req_direct
		|=> deny_reg) else $error("direct option write not refused");
	a_flash_lock: assert property (
		req_valid && req_area == `FRP_AREA_FLASH && restricted && !security_extension_enable
		&& readout_protect_level == `FRP_LVL_1 |=> deny_reg) else $error("locked flash reached");
	a_wp_deny: assert property (
		req_valid && req_area == `FRP_AREA_FLASH && req_op != `FRP_OP_READ && !req_bank
		&& wp_a_en && req_page >= wp_a_start && req_page <= wp_a_end |=> deny_reg)
		else $error("protected page changed");
	a_wipe_order: assert property (
		$rose(wipe_busy_reg) |-> s_wipe ##[1:WS] !wipe_busy_reg)
		else $error("wipe steps out of order or late");
	a_l2_locked: assert property (
		readout_protect_level == `FRP_LVL_2 && $past(readout_protect_level) == `FRP_LVL_2
		|-> !(debug_enable_reg | ram_boot_enable_reg | loader_enable_reg))
		else $error("debug or boot path open at top level");
	a_ecc_fail: assert property (
		ecc_valid && ecc_double |=> ecc_failed_reg && ecc_fail_addr_reg == $past(ecc_addr))
		else $error("double error not flagged with address");
	a_ecc_fix: assert property (
		ecc_valid && ecc_single && !ecc_double |=> ecc_corrected_reg && !ecc_failed_reg)
		else $error("single error not corrected");
endmodule // frp_guard_monitor
bind frp_guard frp_guard_monitor #(.PAGE_BITS(PAGE_BITS), .WIPE_CYC(WIPE_CYC)) u_mon (.*);

// *** frp_map.vh ***
// Constants for the flash readout protection block: level codes, areas,
// operations, geometry and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef FRP_MAP_VH
`define FRP_MAP_VH

// Protection level encodings
`define FRP_LVL_0        2'h0
`define FRP_LVL_HALF     2'h1
`define FRP_LVL_1        2'h2
`define FRP_LVL_2        2'h3

// Target areas
`define FRP_AREA_FLASH   3'h0
`define FRP_AREA_SYSMEM  3'h1
`define FRP_AREA_OPTION  3'h2
`define FRP_AREA_OTP     3'h3
`define FRP_AREA_BKPREG  3'h4
`define FRP_AREA_SRAM    3'h5
`define FRP_AREA_DECRYPT 3'h6

// Access operations
`define FRP_OP_READ      2'h0
`define FRP_OP_WRITE     2'h1
`define FRP_OP_ERASE     2'h2

// Flash geometry: 2 banks of 128 pages of 8 Kbytes
`define FRP_PAGES        128
`define FRP_PAGE_BITS    7
`define FRP_PAGE_KBYTES  8
`define FRP_OTP_WORDS    32
`define FRP_OTP_BITS     5

// Regression wipe: time per mass-erase step, ns, and cycles at 5 ns
`define FRP_WIPE_STEP_NS 40
`define FRP_CLK_NS       5
`define FRP_WIPE_CYC     ((`FRP_WIPE_STEP_NS + `FRP_CLK_NS - 1) / `FRP_CLK_NS)

// Reset values
`define FRP_PREFETCH_RST 1'h0

`endif

// *** frp_otp_mem.v ***
// One-time area: storage with a written flag per word.
// Assumes single-port use from the access checker; read data registered.
`timescale 1ns/100ps
`include "frp_map.vh"

module frp_otp_mem #(
	parameter WIDTH = 32,
	parameter ABITS = `FRP_OTP_BITS
)(
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             wr_en,
	input  wire [ABITS-1:0] addr,
	input  wire [WIDTH-1:0] wr_data,
	output reg  [WIDTH-1:0] rd_data_reg,
	output wire             used
);
	localparam DEPTH = 1 << ABITS;

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [DEPTH-1:0] used_reg;

	// Flag tells the checker a location is spent
	assign used = used_reg[addr];

	// Data array has no reset; the flags carry the meaning
	always @(posedge sys_clk)
	begin
		if (wr_en && !used_reg[addr])
			mem[addr] <= wr_data;
		rd_data_reg <= mem[addr];
	end

	// Written flags, set once and cleared only by reset
	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			used_reg <= {DEPTH{1'b0}};
		else if (wr_en)
			used_reg[addr] <= 1'b1;
	end
endmodule // frp_otp_mem

// *** frp_probe_model.sv ***
// Debug probe model: presents a password over the debug link on request.
// Assumes the bench raises present for one cycle; acts on rising edges.
`timescale 1ns/100ps
module frp_probe_model (
	input  logic        sys_clk,
	input  logic        present,
	input  logic [63:0] key,
	output logic        pwd_valid,
	output logic [63:0] pwd_value
);
	initial pwd_valid = 1'b0;
	initial pwd_value = 64'h0;
	// One pulse per request; value inverted every cycle after release, so the key returns on alternate cycles
	always @(posedge sys_clk)
		if (present && !pwd_valid)
		begin
			pwd_valid <= 1'b1;
			pwd_value <= key;
		end
		else
		begin
			pwd_valid <= 1'b0;
			pwd_value <= ~pwd_value;
		end
endmodule // frp_probe_model

// *** tb.sv ***
// Self-checking bench for the readout protection access guard.
// Assumes 200 MHz clock, inputs on falling edges, probe model for passwords.
`timescale 1ns/100ps
`include "frp_map.vh"
module tb;
	localparam int         WC    = 8;
	localparam logic [2:0] ans_g = 3'h4;
	localparam logic [2:0] ans_d = 3'h2;
	localparam logic [2:0] ans_w = 3'h1;
	logic        sys_clk, rst, security_extension_enable, opt_key_set, opt_pwd_needed;
	logic        wp_a_en, wp_b_en, wp_c_en, wp_d_en, debug_connected, debug_secure;
	logic        boot_ram, boot_loader, req_valid, req_secure, req_bank, req_direct;
	logic        opt_swap_only, option_update_start, pwd_valid, bank_busy_0, bank_busy_1;
	logic        ecc_valid, ecc_single, ecc_double, prefetch_enable, present, bk;
	logic [1:0]  opt_level, req_op, opt_new_level, readout_protect_level, op;
	logic [2:0]  req_area;
	logic [4:0]  req_word;
	logic [6:0]  wp_a_start, wp_a_end, wp_b_start, wp_b_end, wp_c_start, wp_c_end;
	logic [6:0]  wp_d_start, wp_d_end, req_page, pg;
	logic [31:0] req_wdata, ecc_addr, otp_rdata, ecc_fail_addr_reg, lfsr;
	logic [63:0] opt_key, pwd_value, key;
	logic        grant_reg, deny_reg, wait_reg, debug_enable_reg, ram_boot_enable_reg;
	logic        loader_enable_reg, wipe_busy_reg, wipe_flash_reg, wipe_backup_reg;
	logic        wipe_sram_reg, wipe_keys_reg, ecc_corrected_reg, ecc_failed_reg;
	logic        prefetch_on_reg, pwd_ok_reg;
	int          mismatches, n_compared, n;

	frp_guard #(.WIPE_CYC(WC)) DUT (.*);
	frp_probe_model PROBE (.sys_clk(sys_clk), .present(present), .key(key),
		.pwd_valid(pwd_valid), .pwd_value(pwd_value));

	// Free-running 5 ns clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Random source for stimulus
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Inclusive page range test; empty when disabled
	function automatic logic rng(input logic e, input logic [6:0] s, t, p);
		return e && p >= s && p <= t;
	endfunction
	function automatic logic in_wp(input logic b, input logic [6:0] p);
		if (!b)
			return rng(wp_a_en, wp_a_start, wp_a_end, p) | rng(wp_b_en, wp_b_start, wp_b_end, p);
		return rng(wp_c_en, wp_c_start, wp_c_end, p) | rng(wp_d_en, wp_d_start, wp_d_end, p);
	endfunction

	task automatic chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_ans(input logic [2:0] exp);
		n_compared++;
		if ({grant_reg, deny_reg, wait_reg} !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: answer %b, wanted %b", $time,
				{grant_reg, deny_reg, wait_reg}, exp);
		end
	endtask
	// Request held valid so back-to-back calls stay one per cycle
	task automatic req(input logic [2:0] ar, input logic [1:0] o, input logic b,
		input logic [6:0] p, input logic [2:0] exp);
		req_area = ar;
		req_op = o;
		req_bank = b;
		req_page = p;
		req_valid = 1'b1;
		@(negedge sys_clk);
		chk_ans(exp);
	endtask
	task automatic tick();
		req_valid = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic boot(input logic [1:0] lv, input logic sec, ks, pn);
		rst = 1'b1;
		req_valid = 1'b0;
		opt_level = lv;
		security_extension_enable = sec;
		opt_key_set = ks;
		opt_pwd_needed = pn;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask
	task automatic upd(input logic [1:0] nl);
		tick();
		opt_new_level = nl;
		option_update_start = 1'b1;
		@(negedge sys_clk);
		option_update_start = 1'b0;
	endtask
	task automatic pwd(input logic [63:0] k);
		tick();
		key = k;
		present = 1'b1;
		@(negedge sys_clk);
		present = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic ecc(input logic s, d, input logic [1:0] exp);
		tick();
		lfsr = nx(lfsr);
		ecc_addr = lfsr;
		ecc_single = s;
		ecc_double = d;
		ecc_valid = 1'b1;
		@(negedge sys_clk);
		ecc_valid = 1'b0;
		chk({ecc_corrected_reg, ecc_failed_reg}, exp);
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatched %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Run is a few hundred cycles; this cuts a hang well beyond that
	initial
	begin
		#50000;
		mismatches++;
		complete_run();
	end

	// Main sequence
	initial
	begin
		lfsr = 32'h88110B82;
		mismatches = 0;
		n_compared = 0;
		rst = 1'b1;
		{security_extension_enable, opt_key_set, opt_pwd_needed, debug_connected, debug_secure,
			boot_ram, boot_loader, req_valid, req_secure, req_bank, req_direct, opt_swap_only,
			option_update_start, bank_busy_0, bank_busy_1, ecc_valid, ecc_single, ecc_double,
			prefetch_enable, present, opt_level, req_op, opt_new_level, req_area, req_word,
			req_page, req_wdata, ecc_addr, key} = '0;
		opt_key = {lfsr, ~lfsr};
		{wp_a_start, wp_a_end, wp_a_en, wp_b_en, wp_c_en} = {7'h0A, 7'h14, 3'h7};
		wp_b_start = 7'h40 + lfsr[4:0];
		wp_b_end = wp_b_start + lfsr[9:6];
		wp_c_start = lfsr[14:10];
		wp_c_end = wp_c_start + lfsr[18:15];
		{wp_d_start, wp_d_end, wp_d_en} = {7'h60 + lfsr[23:20], 7'h7F, lfsr[24]};
		boot(`FRP_LVL_0, 1'b0, 1'b0, 1'b0);
		chk(readout_protect_level, `FRP_LVL_0);
		chk(prefetch_on_reg, 1'b0);
		prefetch_enable = 1'b1;
		tick();
		chk(prefetch_on_reg, 1'b1);
		// Boundary pages around the first area, then random traffic
		foreach (wp_a_end[i])
			req(`FRP_AREA_FLASH, `FRP_OP_WRITE, 1'b0, 7'h09 + i[2:0] * 3'h2,
				in_wp(1'b0, 7'h09 + i[2:0] * 3'h2) ? ans_d : ans_g);
		repeat (40)
		begin
			lfsr = nx(lfsr);
			{op, bk, pg, req_secure} = {lfsr[9:8] % 2'd3, lfsr[10], lfsr[6:0], lfsr[11]};
			req(`FRP_AREA_FLASH, op, bk, pg, op != 2'd0 && in_wp(bk, pg) ? ans_d : ans_g);
			req(`FRP_AREA_SYSMEM, op, bk, pg, op == 2'd0 ? ans_g : ans_d);
		end
		bank_busy_1 = 1'b1;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h05, ans_g);
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b1, 7'h05, ans_w);
		bank_busy_1 = 1'b0;
		req_direct = 1'b1;
		req(`FRP_AREA_OPTION, `FRP_OP_WRITE, 1'b0, 7'h00, ans_d);
		req_direct = 1'b0;
		req(`FRP_AREA_OPTION, `FRP_OP_WRITE, 1'b0, 7'h00, ans_g);
		{req_word, req_wdata} = {lfsr[4:0], nx(lfsr)};
		req(`FRP_AREA_OTP, `FRP_OP_WRITE, 1'b0, 7'h00, ans_g);
		req(`FRP_AREA_OTP, `FRP_OP_WRITE, 1'b0, 7'h00, ans_d);
		req(`FRP_AREA_OTP, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		tick();
		chk(otp_rdata, req_wdata);
		ecc(1'b1, 1'b0, 2'b10);
		ecc(1'b0, 1'b1, 2'b01);
		chk(ecc_fail_addr_reg, lfsr);
		// Level 1: restricted contexts locked out, regression wipes
		boot(`FRP_LVL_1, 1'b0, 1'b0, 1'b0);
		{debug_connected, boot_ram, boot_loader} = 3'b100;
		for (int a = 0; a < 6; a += 4)
			req(a[2:0], `FRP_OP_READ, 1'b0, 7'h00, ans_d);
		req(`FRP_AREA_SYSMEM, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		{debug_connected, boot_ram} = 2'b01;
		req(`FRP_AREA_FLASH, `FRP_OP_WRITE, 1'b1, 7'h70, ans_d);
		{boot_ram, boot_loader} = 2'b01;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_d);
		boot_loader = 1'b0;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		upd(`FRP_LVL_0);
		chk(readout_protect_level, `FRP_LVL_0);
		chk({wipe_flash_reg, wipe_backup_reg, wipe_sram_reg, wipe_keys_reg}, 4'h8);
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_d);
		for (n = 0; wipe_busy_reg === 1'b1 && n < 100; n++)
			@(negedge sys_clk);
		chk(n, 4 * WC - 1);
		debug_connected = 1'b1;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		debug_connected = 1'b0;
		// Password-guarded regression from level 1
		boot(`FRP_LVL_1, 1'b0, 1'b1, 1'b1);
		upd(`FRP_LVL_0);
		chk(readout_protect_level, `FRP_LVL_1);
		pwd(~opt_key);
		chk(pwd_ok_reg, 1'b0);
		pwd(opt_key);
		chk(pwd_ok_reg, 1'b1);
		upd(`FRP_LVL_0);
		chk(readout_protect_level, `FRP_LVL_0);
		// Level 2 without key: locked, only bank swap writable
		boot(`FRP_LVL_2, 1'b0, 1'b0, 1'b0);
		chk({debug_enable_reg, ram_boot_enable_reg, loader_enable_reg}, 3'h0);
		req(`FRP_AREA_OPTION, `FRP_OP_WRITE, 1'b0, 7'h00, ans_d);
		opt_swap_only = 1'b1;
		req(`FRP_AREA_OPTION, `FRP_OP_WRITE, 1'b0, 7'h00, ans_g);
		pwd(opt_key);
		upd(`FRP_LVL_1);
		chk(readout_protect_level, `FRP_LVL_2);
		// Level 2 with key regresses after password
		boot(`FRP_LVL_2, 1'b0, 1'b1, 1'b0);
		pwd(opt_key);
		chk(pwd_ok_reg, 1'b1);
		upd(`FRP_LVL_1);
		chk(readout_protect_level, `FRP_LVL_1);
		// Level 0.5 needs the security extension; then level 1 with it admits non-secure debug
		boot(`FRP_LVL_HALF, 1'b0, 1'b0, 1'b0);
		chk(readout_protect_level, `FRP_LVL_1);
		boot(`FRP_LVL_HALF, 1'b1, 1'b0, 1'b0);
		chk(readout_protect_level, `FRP_LVL_HALF);
		{debug_connected, req_secure} = 2'b10;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		req_secure = 1'b1;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_d);
		debug_connected = 1'b0;
		boot(`FRP_LVL_1, 1'b1, 1'b0, 1'b0);
		chk({debug_enable_reg, ram_boot_enable_reg}, 2'b10);
		{debug_connected, req_secure} = 2'b10;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_g);
		req_secure = 1'b1;
		req(`FRP_AREA_FLASH, `FRP_OP_READ, 1'b0, 7'h00, ans_d);
		complete_run();
	end
endmodule // tb
